// ### core/filter_bag_break_monitor.sv
// filter bag break monitor: sync-triggered slot stepping and defect capture
// What this block does
// - sync pulse arrives on cleaning sync input; it starts each supervision cycle
// - each bag peak is evaluated, slot counter attributes violations to bags
// - with relay use enabled, relay two shows a detected filter break
// - cycle ends after stepping through the configured number of bags
// - slot advances after the configured interval between bags
// - evaluation waits the configured delay after the sync pulse
// - break flagged when damped concentration reaches the limit
// - supervision uses its own damped concentration with own response setting
// - enabled but idle shows waiting for start pulse
// - running count of measured cycles, cleared to zero at restart
// - current bag slot index is exposed
// - defective bag indices read out one at a time by list index; host separates them with semicolons
// - each new start pulse clears the stored defect result
`timescale 1ns/1ps
`default_nettype none
module filter_bag_break_monitor
    import filter_watch_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // configuration
    input wire logic enable,
    input wire logic useLimitRelay,
    input wire logic [BAG_W-1:0] bagCount,
    input wire logic [TIME_W-1:0] intervalMs,
    input wire logic [TIME_W-1:0] delayMs,
    input wire logic [CONC_W-1:0] limitValue,
    input wire logic [DAMP_SHIFT_W-1:0] responseShift,
    // measurement and plant pin
    input wire logic [CONC_W-1:0] concentration,
    input wire logic cleaningSyncInput,
    // defect list readout
    input wire logic [BAG_W-1:0] listReadIndex,
    // status
    output logic waitingForStart,
    output logic cycleActive,
    output logic [CYC_W-1:0] cycleCount,
    output logic [BAG_W-1:0] filterNumber,
    output logic filterBreak,
    output logic relayTwo,
    output logic [CONC_W-1:0] filterConcentration,
    // defect list: the n-th defective bag, n taken from listReadIndex
    output logic [BAG_W-1:0] defectCount,
    output logic [BAG_W-1:0] listEntry,
    output logic listEntryValid
);
    // sync pin: three stages, change accepted when second and third agree
    logic sync1_q, sync2_q, sync3_q, syncLevel_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            syncLevel_q <= 1'b0;
        end else begin
            sync1_q <= cleaningSyncInput;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            if (sync2_q == sync3_q) begin
                syncLevel_q <= sync3_q;
            end
        end
    end
    wire logic syncRise = (sync2_q == sync3_q) && sync3_q && !syncLevel_q;

    // millisecond tick
    logic [TICK_CW-1:0] tickCnt_q;
    wire logic tick = (tickCnt_q == TICK_CW'(TICK_CYCLES - 1));
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tickCnt_q <= '0;
        end else begin
            tickCnt_q <= tick ? '0 : tickCnt_q + 1'b1;
        end
    end

    // separate first-order damping; main concentration path is untouched
    logic [CONC_W+15:0] damp_q;
    wire logic [CONC_W+15:0] concWide = {concentration, 16'h0000};
    wire logic [CONC_W+15:0] dampStep = (concWide >> responseShift) - (damp_q >> responseShift);
    wire logic [CONC_W-1:0] dampedConc = damp_q[CONC_W+15:16];
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            damp_q <= '0;
        end else if (tick) begin
            damp_q <= damp_q + dampStep;
        end
    end

    // cycle sequencer
    watch_state_t state_q, state_d;
    logic [TIME_W-1:0] msCnt_q;
    logic [BAG_W-1:0] slot_q;
    logic [CONC_W-1:0] peak_q;
    logic [MAX_BAGS-1:0] defect_q;
    logic [CYC_W-1:0] cycles_q;

    // unsigned threshold test shared by the delay, interval, last-slot and limit compares
    function automatic logic reached(input logic [TIME_W-1:0] val, input logic [TIME_W-1:0] lim);
        return val >= lim;
    endfunction

    wire logic startCycle = enable && syncRise;
    wire logic [TIME_W-1:0] msNext = msCnt_q + 1'b1;
    wire logic [BAG_W-1:0] slotNext = slot_q + 1'b1;
    wire logic delayDone = (state_q == DELAY) && tick && reached(msCnt_q, delayMs);
    wire logic slotDone = (state_q == SLOT) && tick && reached(msNext, intervalMs);
    wire logic lastSlot = reached(TIME_W'(slotNext), TIME_W'(bagCount));
    wire logic [CONC_W-1:0] peakNow = (dampedConc > peak_q) ? dampedConc : peak_q;
    wire logic slotBroken = reached(peakNow, limitValue);
    // a slot closes only in a live cycle that no new start overrides
    wire logic slotClose = enable && !startCycle && slotDone;

    // next state; a start or a drop of enable overrides any phase
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            IDLE: begin
                state_d = IDLE;
            end
            DELAY: begin
                if (delayDone) begin
                    state_d = SLOT;
                end
            end
            SLOT: begin
                if (slotDone && lastSlot) begin
                    state_d = IDLE;
                end
            end
            default: begin
                state_d = IDLE;
            end
        endcase
        if (startCycle) begin
            state_d = DELAY;
        end
        if (!enable) begin
            state_d = IDLE;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ms counter restarts at a start and at the end of the delay and of every slot
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            msCnt_q <= '0;
        end else if (startCycle || delayDone || slotDone) begin
            msCnt_q <= '0;
        end else if (tick && state_q != IDLE) begin
            msCnt_q <= msNext;
        end
    end

    // slot index stays on the last bag after the cycle ends
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            slot_q <= '0;
        end else if (startCycle) begin
            slot_q <= '0;
        end else if (slotClose && !lastSlot) begin
            slot_q <= slotNext;
        end
    end

    // peak of the damped value within the running slot
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            peak_q <= '0;
        end else if (startCycle || slotDone) begin
            peak_q <= '0;
        end else if (state_q == SLOT) begin
            peak_q <= peakNow;
        end
    end

    // defect bits, one per bag; a start clears, as the old cycle is void
    for (genvar b = 0; b < MAX_BAGS; b++) begin : g_defect
        wire logic hitHere = slotClose && slotBroken && (slot_q == BAG_W'(b));
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                defect_q[b] <= 1'b0;
            end else if (startCycle) begin
                defect_q[b] <= 1'b0;
            end else if (hitHere) begin
                defect_q[b] <= 1'b1;
            end
        end
    end

    // cycle total; a restart is a reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cycles_q <= CYCLES_RESET;
        end else if (slotClose && lastSlot) begin
            cycles_q <= cycles_q + 1'b1;
        end
    end

    // list readout: the n-th set bit; host prints them with ';' between
    // a linear scan is costly but keeps readout simple and stateless
    logic [BAG_W-1:0] nthBag;
    logic nthFound;
    logic [BAG_W:0] popCnt;
    always_comb begin
        logic [BAG_W:0] seen;
        seen = '0;
        nthBag = '0;
        nthFound = 1'b0;
        for (int i = 0; i < MAX_BAGS; i++) begin
            if (defect_q[i]) begin
                if (!nthFound && seen == {1'b0, listReadIndex}) begin
                    nthBag = BAG_W'(i);
                    nthFound = 1'b1;
                end
                seen = seen + 1'b1;
            end
        end
        popCnt = seen;
    end

    // registered outputs, one flop group each
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            waitingForStart <= 1'b0;
        end else begin
            waitingForStart <= enable && (state_q == IDLE);
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cycleActive <= 1'b0;
        end else begin
            cycleActive <= (state_q != IDLE);
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cycleCount <= CYCLES_RESET;
        end else begin
            cycleCount <= cycles_q;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            filterNumber <= '0;
        end else begin
            filterNumber <= slot_q;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            filterBreak <= 1'b0;
        end else begin
            filterBreak <= |defect_q;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            relayTwo <= 1'b0;
        end else begin
            relayTwo <= useLimitRelay && (|defect_q);
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            filterConcentration <= '0;
        end else begin
            filterConcentration <= dampedConc;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            defectCount <= '0;
        end else begin
            defectCount <= popCnt[BAG_W-1:0];
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            listEntry <= '0;
        end else begin
            listEntry <= nthBag;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            listEntryValid <= 1'b0;
        end else begin
            listEntryValid <= nthFound;
        end
    end
endmodule
`default_nettype wire

// ### core/filter_watch_pkg.sv
// constants and types for the filter bag break monitor
package filter_watch_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int BAG_W = 8;
    localparam int MAX_BAGS = 256;
    localparam int CONC_W = 16;
    localparam int TIME_W = 16;
    localparam int CYC_W = 16;
    localparam int DAMP_SHIFT_W = 4;
    // configured times are given in milliseconds
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICK_CW = 15;
    localparam logic [CYC_W-1:0] CYCLES_RESET = 16'h0000;
    typedef enum logic [1:0] {IDLE, DELAY, SLOT} watch_state_t;
endpackage

// ### test/filter_watch_assertions.sv
// port assertions for the filter bag break monitor
`timescale 1ns/1ps
`default_nettype none
module filter_watch_assertions
    import filter_watch_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // configuration
    input wire logic enable,
    input wire logic useLimitRelay,
    input wire logic [BAG_W-1:0] bagCount,
    // status
    input wire logic waitingForStart,
    input wire logic cycleActive,
    input wire logic [CYC_W-1:0] cycleCount,
    input wire logic [BAG_W-1:0] filterNumber,
    input wire logic filterBreak,
    input wire logic relayTwo,
    input wire logic [BAG_W-1:0] defectCount
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_relay_off: assert property ((!useLimitRelay)[*3] |-> !relayTwo)
        else $error("relay on while unused");
    a_break_flag: assert property (defectCount != 8'h00 |-> ##[0:2] filterBreak)
        else $error("defect without break");
    a_active_wait: assert property (cycleActive |-> !waitingForStart)
        else $error("waiting while active");
    a_idle_off: assert property ((!enable)[*3] |-> !waitingForStart && !cycleActive)
        else $error("busy while disabled");
    a_count_step: assert property ($changed(cycleCount) |->
        cycleCount == $past(cycleCount) + 16'h0001)
        else $error("cycle count jump");
    a_count_end: assert property ($changed(cycleCount) |-> ##[0:4] !cycleActive)
        else $error("cycle not ended");
    a_slot_range: assert property (filterNumber < bagCount || filterNumber == 8'h00)
        else $error("slot out of range");
    a_start_clear: assert property ($rose(cycleActive) |-> ##[0:2] defectCount == 8'h00)
        else $error("defects kept at start");
endmodule
bind filter_bag_break_monitor filter_watch_assertions filter_watch_assertions_i (.clk, .reset,
    .enable, .useLimitRelay, .bagCount, .waitingForStart, .cycleActive, .cycleCount,
    .filterNumber, .filterBreak, .relayTwo, .defectCount);
`default_nettype wire

// ### test/plant_sync.sv
// plant cleaning controller model: sync pulse source
`timescale 1ns/1ps
`default_nettype none
module plant_sync #(parameter int HOLD = 20) (
    input wire logic clk,
    input wire logic fire,
    output logic syncPin
);
    int n = 0;
    // pulse shortened from 100..900 ms, else the run is millions of cycles
    always @(posedge clk) begin
        if (fire)
            n <= HOLD;
        else if (n > 0)
            n <= n - 1;
    end
    assign syncPin = (n > 0);
endmodule
`default_nettype wire

// ### test/filter_bag_break_monitor_tb.sv
// self-checking bench for the filter bag break monitor
`timescale 1ns/1ps
`default_nettype none
module filter_bag_break_monitor_tb;
    import filter_watch_pkg::*;
    logic clk = 0, reset = 1, enable = 1, useLimitRelay = 1, fire = 0, cleaningSyncInput;
    logic [BAG_W-1:0] bagCount = 8'h02, listReadIndex = 8'h00;
    logic [TIME_W-1:0] intervalMs = 16'h0001, delayMs = 16'h0000;
    logic [CONC_W-1:0] limitValue = 16'h0100, concentration = 16'h0100;
    logic [DAMP_SHIFT_W-1:0] responseShift = 4'h0;
    logic waitingForStart, cycleActive, filterBreak, relayTwo, listEntryValid;
    logic [CYC_W-1:0] cycleCount;
    logic [BAG_W-1:0] filterNumber, defectCount, listEntry;
    logic [CONC_W-1:0] filterConcentration;
    int err_total = 0, n_checks = 0;
    initial forever #20 clk = ~clk;
    plant_sync plant_sync_i (.clk, .fire, .syncPin(cleaningSyncInput));
    filter_bag_break_monitor filter_bag_break_monitor_i (.clk, .reset, .enable, .useLimitRelay,
        .bagCount, .intervalMs, .delayMs, .limitValue, .responseShift, .concentration,
        .cleaningSyncInput, .listReadIndex, .waitingForStart, .cycleActive, .cycleCount,
        .filterNumber, .filterBreak, .relayTwo, .filterConcentration, .defectCount, .listEntry,
        .listEntryValid);
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // bounded wait, one slot is 25000 clocks
    task automatic waitActive(input logic v);
        int k;
        k = 0;
        while (cycleActive !== v && k < 90000) begin
            @(posedge clk);
            #1;
            k++;
        end
        check("cycleActive", cycleActive, v);
    endtask
    task automatic pulse();
        @(posedge clk) fire <= 1;
        @(posedge clk) fire <= 0;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        reset <= 0;
        repeat (2) @(posedge clk);
        #1;
        check("cycleCount", cycleCount, 16'h0000);
        check("waiting", waitingForStart, 1);
        pulse();
        waitActive(1);
        check("waiting", waitingForStart, 0);
        check("slot", filterNumber, 8'h00);
        waitActive(0);
        check("cycleCount", cycleCount, 16'h0001);
        check("break", filterBreak, 1);
        check("relay", relayTwo, 1);
        check("damped", filterConcentration, 16'h0100);
        check("defects", defectCount, 8'h02);
        check("entry", listEntry, 8'h00);
        check("entryValid", listEntryValid, 1);
        check("slot", filterNumber, 8'h01);
        @(posedge clk);
        listReadIndex <= 8'h01;
        useLimitRelay <= 0;
        concentration <= 16'h00ff;
        repeat (3) @(posedge clk);
        #1;
        check("entry", listEntry, 8'h01);
        check("entryValid", listEntryValid, 1);
        check("relay", relayTwo, 0);
        @(posedge clk);
        listReadIndex <= 8'h02;
        repeat (3) @(posedge clk);
        #1;
        check("entryValid", listEntryValid, 0);
        pulse();
        waitActive(1);
        repeat (3) @(posedge clk);
        #1;
        check("defects", defectCount, 8'h00);
        check("break", filterBreak, 0);
        check("slot", filterNumber, 8'h00);
        @(posedge clk);
        enable <= 0;
        repeat (4) @(posedge clk);
        #1;
        check("active", cycleActive, 0);
        check("waiting", waitingForStart, 0);
        test_done();
    end
    // two slots plus delay take about three ticks of 25000 clocks
    initial begin
        repeat (95000) @(posedge clk);
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire
